// ---- design/dds_consts.svh ----
// constants for the synthesis core: register indices, bit positions, counts
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_CTRL_ONE 6'h00
`define IDX_CTRL_TWO 6'h01
`define IDX_CTRL_FOUR 6'h03
`define IDX_MOD_FTW 6'h04
`define IDX_MOD_B 6'h05
`define IDX_MOD_A 6'h06
`define IDX_RAMP_STEP 6'h08
`define IDX_RAMP_LOW 6'h09
`define IDX_RAMP_HIGH 6'h0A
`define IDX_STATUS 6'h0C
`define IDX_PROF_BASE 6'h10
`define IDX_PROF_LAST 6'h1F
// control one fields
`define BIT_AMP_EN 8
`define BIT_SINE_SEL 16
// control two fields
`define BIT_PROF_EN 23
`define BIT_PAR_EN 22
`define POS_RAMP_DEST 20
`define POS_PAR_DEST 18
`define BIT_RAMP_EN 17
`define BIT_MOD_EN 16
// control four fields
`define BIT_CAL_EN 24
// reset values
`define RST_WORD 32'h0000_0000
`define RST_MOD_B 32'h0000_0002
// timing and waveform constants
`define DIV_LAST 4'hF
`define CAL_CYCLES_DFLT 469632
`define SYNC_PERIODS 5'h10
`define AMP_FULL 12'hFFF
`define DAC_MID 12'h800
`define COS_SHIFT 16'h4000
`endif

// ---- design/dds_pkg.sv ----
// types shared by the synthesis core
package dds_pkg;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_SYNC = 3'b100
  } calState_t;
  typedef enum logic [1:0] {
    DEST_FREQ = 2'h0,
    DEST_PHASE = 2'h1,
    DEST_AMP = 2'h2
  } paramDest_t;
endpackage

// ---- design/dds_param_priority_core.sv ----
// synthesis core with parameter source priority, apb registers and calibration
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "dds_consts.svh"

// What this block does
// - frequency picks modulus, then ramp, then profile, then parallel port; phase and amplitude have no modulus source
// - profile and parallel both on frequency: profile wins
// - modulus mode owns frequency; all other frequency sources ignored
// - ramp never sweeps phase or amplitude while modulus mode runs
// - amplitude scaling applies only when amplitude enable is set
// - while ramp sweeps one parameter the other two come from profile, or from parallel port if it is aimed there without profile
// - profile mode alone drives frequency and phase from selected profile, and amplitude too when amplitude enable is set
// - control one bit 16 picks sine or cosine output
// - output frequency is tuning word over two to the 32 times clock
// - 16-bit phase offset added to accumulated phase before conversion
// - converter output multiplied by 12-bit scale over 4096
// - parameters update at most once every sixteen clocks
// - rising calibration enable starts the converter clock tuning routine
// - calibration lasts 469,632 clock cycles
// - with sync in use calibration adds 16 sync clock periods
// - data clock output runs at one sixteenth of the sample clock
// - profile pin change loads its parameters at next data clock falling edge
module dds_param_priority_core #(
  parameter int CAL_CYCLES = `CAL_CYCLES_DFLT // calibration length
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic nrst, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic [2:0] profile_select_pins, // profile choice
  input wire logic [31:0] parData, // parallel data port
  input wire logic rampDown, // ramp direction, high falls
  input wire logic rampHold, // ramp pause
  input wire logic syncUsed, // multi-device sync in use
  input wire logic syncClkIn, // sync input clock, sampled
  output logic dataClk, // parallel data clock
  output logic calBusy, // calibration running
  output logic [11:0] dacData // converter code, offset binary
);
  import dds_pkg::*;

  ////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] ctrlOne, ctrlTwo, ctrlFour;
  logic [31:0] modFtw, modB, modA;
  logic [31:0] rampStep, rampLow, rampHigh;
  logic [31:0] profFreq [8];
  logic [31:0] profPa [8];
  logic [5:0] idx;
  logic wrEn, mapped;
  logic [31:0] next_prdata;

  function automatic logic isProfile(input logic [5:0] i);
    isProfile = (i >= `IDX_PROF_BASE) && (i <= `IDX_PROF_LAST);
  endfunction

  assign idx = paddr[7:2];
  assign wrEn = psel && penable && pwrite;
  // zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // address decode, shared by read mux and error
  always_comb begin
    mapped = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0);
    case (idx)
      `IDX_CTRL_ONE, `IDX_CTRL_TWO, `IDX_CTRL_FOUR, `IDX_MOD_FTW,
      `IDX_MOD_B, `IDX_MOD_A, `IDX_RAMP_STEP, `IDX_RAMP_LOW,
      `IDX_RAMP_HIGH, `IDX_STATUS: mapped = mapped;
      default: mapped = mapped && isProfile(idx);
    endcase
  end

  // control registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlOne <= `RST_WORD;
      ctrlTwo <= `RST_WORD;
      ctrlFour <= `RST_WORD;
      modFtw <= `RST_WORD;
      modB <= `RST_MOD_B;
      modA <= `RST_WORD;
      rampStep <= `RST_WORD;
      rampLow <= `RST_WORD;
      rampHigh <= `RST_WORD;
    end else if (wrEn && mapped) begin
      case (idx)
        `IDX_CTRL_ONE: ctrlOne <= pwdata;
        `IDX_CTRL_TWO: ctrlTwo <= pwdata;
        `IDX_CTRL_FOUR: ctrlFour <= pwdata;
        `IDX_MOD_FTW: modFtw <= pwdata;
        `IDX_MOD_B: modB <= pwdata;
        `IDX_MOD_A: modA <= pwdata;
        `IDX_RAMP_STEP: rampStep <= pwdata;
        `IDX_RAMP_LOW: rampLow <= pwdata;
        `IDX_RAMP_HIGH: rampHigh <= pwdata;
        default: ;
      endcase
    end
  end

  // profile registers, two words each: frequency, then phase and amplitude
  for (genvar p = 0; p < 8; p++) begin : g_prof
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        profFreq[p] <= `RST_WORD;
        profPa[p] <= `RST_WORD;
      end else if (wrEn && mapped && isProfile(idx) && idx[3:1] == 3'(p)) begin
        if (idx[0]) begin
          profPa[p] <= pwdata;
        end else begin
          profFreq[p] <= pwdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control fields
  logic ampEn, sineSel, profEn, parEn, rampEn, modEn;
  logic [1:0] rampDest, parDest;
  assign ampEn = ctrlOne[`BIT_AMP_EN];
  assign sineSel = ctrlOne[`BIT_SINE_SEL];
  assign profEn = ctrlTwo[`BIT_PROF_EN];
  assign parEn = ctrlTwo[`BIT_PAR_EN];
  assign rampEn = ctrlTwo[`BIT_RAMP_EN];
  assign modEn = ctrlTwo[`BIT_MOD_EN];
  assign rampDest = ctrlTwo[`POS_RAMP_DEST +: 2];
  assign parDest = ctrlTwo[`POS_PAR_DEST +: 2];

  ////////////////////////////////////////////////////////////////
  // slow tick divider; data clock is its top bit
  logic [3:0] divCnt;
  logic tick;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt <= 4'h0;
    end else begin
      divCnt <= divCnt + 4'h1;
    end
  end
  assign tick = (divCnt == `DIV_LAST);
  assign dataClk = divCnt[3];

  ////////////////////////////////////////////////////////////////
  // ramp generator, doubling as the modulus auxiliary accumulator
  logic [31:0] rampVal, auxAcc;
  logic [32:0] auxSum;
  logic auxCarry;
  assign auxSum = {1'b0, auxAcc} + {1'b0, modA};
  assign auxCarry = modEn && (auxSum >= {1'b0, modB});

  // ramp steps only on ticks and is frozen in modulus mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rampVal <= `RST_WORD;
    end else if (tick && rampEn && !modEn && !rampHold) begin
      if (rampDown) begin
        rampVal <= (rampVal - rampLow < rampStep) ? rampLow : rampVal - rampStep;
      end else begin
        rampVal <= (rampHigh - rampVal < rampStep) ? rampHigh : rampVal + rampStep;
      end
    end
  end

  // auxiliary accumulator rolls over at the programmed modulus
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      auxAcc <= `RST_WORD;
    end else if (!modEn) begin
      auxAcc <= `RST_WORD;
    end else if (auxCarry) begin
      auxAcc <= 32'(auxSum - {1'b0, modB});
    end else begin
      auxAcc <= auxSum[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // source priority for each parameter
  logic [31:0] next_freq;
  logic [15:0] next_phase;
  logic [11:0] next_amp;
  logic rampLive;
  assign rampLive = rampEn && !modEn; // modulus borrows the ramp

  always_comb begin
    if (modEn) begin
      next_freq = modFtw;
    end else if (rampLive && rampDest == DEST_FREQ) begin
      next_freq = rampVal;
    end else if (profEn || !(parEn && parDest == DEST_FREQ)) begin
      next_freq = profFreq[profile_select_pins];
    end else begin
      next_freq = parData;
    end
  end

  always_comb begin
    if (rampLive && rampDest == DEST_PHASE) begin
      next_phase = rampVal[31:16];
    end else if (profEn || !(parEn && parDest == DEST_PHASE)) begin
      next_phase = profPa[profile_select_pins][15:0];
    end else begin
      next_phase = parData[15:0];
    end
  end

  always_comb begin
    if (!ampEn) begin
      next_amp = `AMP_FULL; // scaling bypassed
    end else if (rampLive && rampDest == DEST_AMP) begin
      next_amp = rampVal[31:20];
    end else if (profEn || !(parEn && parDest == DEST_AMP)) begin
      next_amp = profPa[profile_select_pins][27:16];
    end else begin
      next_amp = parData[11:0];
    end
  end

  // active parameters move only on the slow tick
  logic [31:0] actFreq;
  logic [15:0] actPhase;
  logic [11:0] actAmp;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      actFreq <= `RST_WORD;
      actPhase <= 16'h0;
      actAmp <= `AMP_FULL;
    end else if (tick) begin
      actFreq <= next_freq;
      actPhase <= next_phase;
      actAmp <= next_amp;
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase accumulator; words at or above half range alias
  logic [31:0] phase;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= `RST_WORD;
    end else begin
      phase <= phase + actFreq + {31'h0, auxCarry};
    end
  end

  // quarter-wave table, sixteen points
  function automatic logic [10:0] quarterSine(input logic [3:0] i);
    case (i)
      4'h0: quarterSine = 11'h064;
      4'h1: quarterSine = 11'h12C;
      4'h2: quarterSine = 11'h1EF;
      4'h3: quarterSine = 11'h2B2;
      4'h4: quarterSine = 11'h36C;
      4'h5: quarterSine = 11'h41D;
      4'h6: quarterSine = 11'h4C3;
      4'h7: quarterSine = 11'h55D;
      4'h8: quarterSine = 11'h5EB;
      4'h9: quarterSine = 11'h66B;
      4'hA: quarterSine = 11'h6DA;
      4'hB: quarterSine = 11'h73A;
      4'hC: quarterSine = 11'h787;
      4'hD: quarterSine = 11'h7C2;
      4'hE: quarterSine = 11'h7E9;
      default: quarterSine = 11'h7FD;
    endcase
  endfunction

  // angle to amplitude, then scale
  logic [15:0] angle;
  logic [3:0] lutIdx;
  logic [10:0] mag;
  logic signed [11:0] wave;
  logic signed [24:0] scaled;
  assign angle = phase[31:16] + actPhase + (sineSel ? 16'h0 : `COS_SHIFT);
  assign lutIdx = angle[14] ? ~angle[13:10] : angle[13:10];
  assign mag = quarterSine(lutIdx);
  assign wave = angle[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  assign scaled = wave * $signed({1'b0, actAmp});

  ////////////////////////////////////////////////////////////////
  // calibration sequencer
  calState_t calState, next_calState;
  logic [18:0] calCnt;
  logic [4:0] syncCnt;
  logic calEnPrev, syncPrev, calStart, syncRise;
  assign calStart = ctrlFour[`BIT_CAL_EN] && !calEnPrev; // host pulses the bit
  assign syncRise = syncClkIn && !syncPrev;
  assign calBusy = (calState != CAL_IDLE);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calEnPrev <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      calEnPrev <= ctrlFour[`BIT_CAL_EN];
      syncPrev <= syncClkIn;
    end
  end

  always_comb begin
    case (calState)
      CAL_IDLE: next_calState = calStart ? CAL_RUN : CAL_IDLE;
      CAL_RUN: begin
        if (calCnt == 19'(CAL_CYCLES - 1)) begin
          next_calState = syncUsed ? CAL_SYNC : CAL_IDLE;
        end else begin
          next_calState = CAL_RUN;
        end
      end
      CAL_SYNC: begin
        if (syncRise && syncCnt == `SYNC_PERIODS - 5'h1) begin
          next_calState = CAL_IDLE;
        end else begin
          next_calState = CAL_SYNC;
        end
      end
      default: next_calState = CAL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calState <= CAL_IDLE;
      calCnt <= 19'h0;
      syncCnt <= 5'h0;
    end else begin
      calState <= next_calState;
      calCnt <= (calState == CAL_RUN) ? calCnt + 19'h1 : 19'h0;
      if (calState != CAL_SYNC) begin
        syncCnt <= 5'h0;
      end else if (syncRise) begin
        syncCnt <= syncCnt + 5'h1;
      end
    end
  end

  // converter output frozen while calibrating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dacData <= `DAC_MID;
    end else if (!calBusy) begin
      dacData <= scaled[23:12] + `DAC_MID;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb read data, captured in the setup cycle
  always_comb begin
    case (idx)
      `IDX_CTRL_ONE: next_prdata = ctrlOne;
      `IDX_CTRL_TWO: next_prdata = ctrlTwo;
      `IDX_CTRL_FOUR: next_prdata = ctrlFour;
      `IDX_MOD_FTW: next_prdata = modFtw;
      `IDX_MOD_B: next_prdata = modB;
      `IDX_MOD_A: next_prdata = modA;
      `IDX_RAMP_STEP: next_prdata = rampStep;
      `IDX_RAMP_LOW: next_prdata = rampLow;
      `IDX_RAMP_HIGH: next_prdata = rampHigh;
      `IDX_STATUS: next_prdata = {29'h0, calState};
      default: next_prdata = idx[0] ? profPa[idx[3:1]] : profFreq[idx[3:1]];
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= `RST_WORD;
    end else if (psel && !penable) begin
      prdata <= mapped ? next_prdata : `RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence calKick;
    calStart && calState == CAL_IDLE;
  endsequence

  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("parameter tick too frequent");
  a_dclk_ratio: assert property ($rose(dataClk) |-> ##8 $fell(dataClk))
    else $error("data clock not one sixteenth");
  a_mod_owns_freq: assert property (modEn && tick |=> actFreq == $past(modFtw))
    else $error("modulus did not own frequency");
  a_prof_over_par: assert property (tick && !modEn && profEn && parEn && !rampEn
    |=> actFreq == $past(profFreq[profile_select_pins]))
    else $error("parallel port beat profile");
  a_amp_gate_off: assert property (tick && !ampEn |=> actAmp == `AMP_FULL)
    else $error("amplitude applied while disabled");
  a_ramp_frozen: assert property (modEn && $past(modEn) |-> $stable(rampVal))
    else $error("ramp moved in modulus mode");
  a_cal_starts: assert property (calKick |=> calBusy ##1 calState == CAL_RUN)
    else $error("calibration did not start");
  a_cal_bound: assert property (calState == CAL_RUN |-> calCnt < 19'(CAL_CYCLES))
    else $error("calibration overran");
  a_cal_hold: assert property (calBusy && $past(calBusy) |-> $stable(dacData))
    else $error("output moved during calibration");
  a_phase_step: assert property (!modEn && $past(!modEn)
    |-> phase == 32'($past(phase) + $past(actFreq)))
    else $error("accumulator step wrong");
endmodule // dds_param_priority_core

// ---- verification/host_model.sv ----
// host controller model: apb master for the core plus profile pin driver
`include "dds_consts.svh"

module host_model (
  input wire logic sys_clk, // system clock
  output logic psel, // apb select
  output logic penable, // apb enable
  output logic pwrite, // apb direction
  output logic [31:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  output logic [2:0] profile_select_pins // profile choice
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    profile_select_pins = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one transfer; request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~addr; // released bus never shows a stale address
    pwdata <= ~wdata;
  endtask

  // the host sets the calibration bit, later clears it before any new run
  task automatic calEnable(input logic on);
    logic [31:0] d;
    logic e;
    xfer(1'b1, {24'h00_0000, `IDX_CTRL_FOUR, 2'b00}, {7'h00, on, 24'h00_0000}, d, e);
  endtask

  // profile pins change just after an edge, as a real host would
  task automatic pick(input logic [2:0] p);
    @(posedge sys_clk);
    profile_select_pins <= p;
  endtask
endmodule // host_model

// ---- verification/dds_param_priority_core_test.sv ----
// self-checking bench for the synthesis core with source priority
`include "dds_consts.svh"

module dds_param_priority_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 20; // short calibration keeps the run brief
  `define CHECK_EQ(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
  typedef struct {logic [31:0] addr; logic [31:0] data; logic [31:0] expRd; logic expErr;} row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, dataClk, calBusy, er, frozen;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [31:0] parData = 32'h0000_0000;
  logic rampDown = 1'b0;
  logic rampHold = 1'b0;
  logic syncUsed = 1'b0;
  logic syncRun = 1'b0;
  logic syncClkIn = 1'b0;
  logic [2:0] profile_select_pins;
  logic [11:0] dacData, v, s0, s90, d0;
  int errorCnt = 0;
  int numChecks = 0;
  int syncCnt = 0;
  int n;
  row_t rows [7] = '{'{32'h0000_0014, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{32'h0000_0018, 32'h0000_0004, 32'h0000_0004, 1'b0},
    '{32'h0000_0010, 32'h4CCC_CCCC, 32'h4CCC_CCCC, 1'b0},
    '{32'h0000_0020, 32'h0000_0100, 32'h0000_0100, 1'b0},
    '{32'h0000_007C, 32'h1234_5678, 32'h1234_5678, 1'b0},
    '{32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
    '{32'h0000_0034, 32'hA5A5_A5A5, 32'h0000_0000, 1'b1}};

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock; sync clock runs only while a synchronised run wants it
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    syncCnt <= (syncCnt + 1) % 3;
    if (syncRun && syncCnt == 0) begin
      syncClkIn <= ~syncClkIn;
    end
  end

  dds_param_priority_core #(.CAL_CYCLES(CAL)) i_dds_param_priority_core (.sys_clk(sys_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .profile_select_pins(profile_select_pins), .parData(parData), .rampDown(rampDown),
    .rampHold(rampHold), .syncUsed(syncUsed), .syncClkIn(syncClkIn), .dataClk(dataClk),
    .calBusy(calBusy), .dacData(dacData));
  host_model i_host_model (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .profile_select_pins(profile_select_pins));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] byteAddr(input logic [5:0] idx);
    return {24'h00_0000, idx, 2'b00};
  endfunction
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    i_host_model.xfer(1'b1, byteAddr(idx), d, rd, er);
  endtask
  // wait the given number of rising edges, then sample at a falling edge
  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
    @(negedge sys_clk);
    v = dacData;
  endtask
  // count cycles of calibration; output must not move meanwhile
  task automatic calMeasure();
    i_host_model.calEnable(1'b1);
    // busy rises one edge after the write lands, so skip the first falling edge
    repeat (2) @(negedge sys_clk);
    `CHECK_EQ("calBusy after start", 1'b1, calBusy)
    v = dacData;
    frozen = 1'b1;
    n = 0;
    while (calBusy === 1'b1 && n < 1000) begin
      frozen = frozen & (dacData === v);
      n++;
      @(negedge sys_clk);
    end
    `CHECK_EQ("dacData frozen", 1'b1, frozen)
    i_host_model.calEnable(1'b0);
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    $display("Error watchdog expected finish seen timeout");
    tallyAndFinish();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    `CHECK_EQ("dacData in reset", `DAC_MID, dacData)
    `CHECK_EQ("calBusy in reset", 1'b0, calBusy)
    nrst <= 1'b1;
    i_host_model.xfer(1'b0, byteAddr(`IDX_MOD_B), 32'h0000_0000, rd, er);
    `CHECK_EQ("mod_b reset", `RST_MOD_B, rd)
    $display("test reset done");
    foreach (rows[i]) begin
      i_host_model.xfer(1'b1, rows[i].addr, rows[i].data, rd, er);
      `CHECK_EQ("write err", rows[i].expErr, er)
      i_host_model.xfer(1'b0, rows[i].addr, 32'h0000_0000, rd, er);
      `CHECK_EQ("read data", rows[i].expRd, rd)
      `CHECK_EQ("read err", rows[i].expErr, er)
    end
    $display("test register rows done");
    wait (dataClk === 1'b0);
    wait (dataClk === 1'b1);
    n = 0;
    repeat (16) begin
      @(negedge sys_clk);
      n += dataClk;
    end
    `CHECK_EQ("dataClk high cycles", 8, n)
    @(negedge sys_clk);
    `CHECK_EQ("dataClk period", 1'b1, dataClk)
    $display("test data clock done");
    // frequency zero: output shows phase and waveform choice only
    wr(`IDX_CTRL_TWO, 32'h0080_0000);
    wr(`IDX_PROF_BASE, 32'h0000_0000);
    wr(`IDX_PROF_BASE + 6'h01, 32'h0000_0000);
    wr(`IDX_CTRL_ONE, 32'h0001_0000);
    settle(40);
    s0 = v;
    wr(`IDX_PROF_BASE + 6'h01, 32'h0000_4000);
    settle(40);
    s90 = v;
    `CHECK_EQ("phase offset moves output", 1'b1, s0 !== s90)
    // cosine shifted back a quarter turn lands on the same angle as sine at zero
    wr(`IDX_PROF_BASE + 6'h01, 32'h0000_C000);
    wr(`IDX_CTRL_ONE, 32'h0000_0000);
    settle(40);
    `CHECK_EQ("cosine at three quarter turn", s0, v)
    wr(`IDX_PROF_BASE + 6'h01, 32'h0000_0000);
    wr(`IDX_CTRL_ONE, 32'h0000_0100);
    settle(40);
    `CHECK_EQ("zero scale", `DAC_MID, v)
    wr(`IDX_CTRL_ONE, 32'h0000_0000);
    settle(40);
    `CHECK_EQ("scale ignored when off", s90, v)
    wr(`IDX_PROF_BASE + 6'h01, 32'h0FFF_0000);
    wr(`IDX_CTRL_ONE, 32'h0000_0100);
    settle(40);
    `CHECK_EQ("full scale", s90, v)
    $display("test waveform and scale done");
    // profile one has three quarters of a turn of phase
    wr(`IDX_PROF_BASE + 6'h02, 32'h0000_0000);
    wr(`IDX_PROF_BASE + 6'h03, 32'h0FFF_C000);
    i_host_model.pick(3'h1);
    settle(40);
    `CHECK_EQ("profile one selected", s0, v)
    wr(`IDX_CTRL_TWO, 32'h00C0_0000);
    @(posedge sys_clk);
    parData <= 32'h4000_0000;
    settle(40);
    `CHECK_EQ("profile beats parallel", s0, v)
    settle(8);
    `CHECK_EQ("profile beats parallel later", s0, v)
    wr(`IDX_CTRL_TWO, 32'h0044_0000);
    @(posedge sys_clk);
    parData <= 32'h0000_0000;
    settle(40);
    `CHECK_EQ("parallel phase alone", s90, v)
    $display("test profile and parallel done");
    // modulus owns frequency; ramp aimed at phase must stay idle
    wr(`IDX_MOD_FTW, 32'h0000_0000);
    wr(`IDX_MOD_A, 32'h0000_0000);
    wr(`IDX_MOD_B, 32'h0000_0002);
    wr(`IDX_RAMP_STEP, 32'h0100_0000);
    wr(`IDX_RAMP_LOW, 32'h0000_0000);
    wr(`IDX_RAMP_HIGH, 32'hFFFF_FFFF);
    wr(`IDX_CTRL_TWO, 32'h0053_0000);
    @(posedge sys_clk);
    parData <= 32'h4000_0000;
    settle(40);
    `CHECK_EQ("modulus holds frequency", s0, v)
    settle(8);
    `CHECK_EQ("ramp kept off phase", s0, v)
    $display("test modulus done");
    // ramp owns frequency but is held at zero; phase and amplitude stay with profile one
    wr(`IDX_PROF_BASE + 6'h02, 32'h4000_0000);
    @(posedge sys_clk);
    rampHold <= 1'b1;
    wr(`IDX_CTRL_TWO, 32'h0082_0000);
    settle(40);
    `CHECK_EQ("ramp frequency, profile phase", s0, v)
    settle(1);
    `CHECK_EQ("ramp frequency still held", s0, v)
    $display("test ramp done");
    // quarter-rate tone repeats every four cycles
    wr(`IDX_CTRL_TWO, 32'h0080_0000);
    wr(`IDX_PROF_BASE + 6'h03, 32'h0FFF_2000);
    wr(`IDX_PROF_BASE + 6'h02, 32'h4000_0000);
    settle(40);
    d0 = v;
    settle(2);
    `CHECK_EQ("half period differs", 1'b1, v !== d0)
    settle(2);
    `CHECK_EQ("full period repeats", d0, v)
    $display("test tone done");
    calMeasure();
    `CHECK_EQ("cal length", CAL, n)
    @(posedge sys_clk);
    syncUsed <= 1'b1;
    syncRun <= 1'b1;
    calMeasure();
    `CHECK_EQ("sync cal length", 1'b1, n >= CAL + 90 && n <= CAL + 102)
    $display("test calibration done");
    tallyAndFinish();
  end
endmodule // dds_param_priority_core_test
